/* rtl/irq_ctrl_defines.vh */
/*
  Register map, field layout and reset values of the nested interrupt controller.
  Assumes that the APB slave decodes the low twelve address bits of its window.
*/
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// Byte offsets inside the controller window.
`define ENABLE_SET_OFS 12'h100
`define ENABLE_CLEAR_OFS 12'h180
`define PENDING_SET_OFS 12'h200
`define PENDING_CLEAR_OFS 12'h280
`define PRIORITY_BASE_OFS 12'h400
`define PRIORITY_LAST_OFS 12'h41C
`define ACTIVE_STATUS_OFS 12'h300
`define TRIGGER_TYPE_OFS 12'h304
`define LINE_LEVEL_OFS 12'h308

// Priority field layout inside each byte lane.
`define PRIO_FIELD_MSB 7
`define PRIO_FIELD_LSB 6
`define PRIO_PAD_BITS 6
`define PRIO_LANES 4
`define PRIO_LOWEST 2'h3

// Reset values.
`define ENABLE_RESET 32'h00000000
`define PENDING_RESET 32'h00000000
`define ACTIVE_RESET 32'h00000000
`define PRIORITY_RESET 64'h0000000000000000
`define TRIGGER_TYPE_RESET 32'h00000000
`define READ_ZERO 32'h00000000
`define FULL_WORD_STROBE 4'hF

`endif

/* rtl/irq_line_sync.v */
/*
  Sampling register for the peripheral interrupt lines.
  Assumes the lines are driven by logic on pclk, so one rising-edge sample is enough
  and a pulse that stands for a single clock cycle is still caught.
*/
`timescale 1ns/10ps
module irq_line_sync #(
  parameter WIDTH = 32
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] level_out
);

  reg [WIDTH-1:0] level_ff;

  // No agreement filter here: the lines share pclk, and a filter would swallow
  // a pulse that stands for only one cycle.
  assign level_out = level_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= {WIDTH{1'b0}};
    end else begin
      level_ff <= async_in;
    end
  end

endmodule

/* rtl/nested_interrupt_state_ctrl.v */
/*
  Nested interrupt controller core: enable, pending and active state of 32 peripheral
  interrupts, 2-bit priorities, level and pulse detection, and selection of the next
  interrupt offered to the processor core.
  Assumes an APB master on pclk, peripheral lines from pclk logic, and a core that reports
  handler entry and return with one-cycle strobes carrying the interrupt number.
*/
// Overview of operation
// - Writing ones to enable-set enables those interrupts; reads show all enables.
// - Writing ones to enable-clear disables those interrupts; reads show all enables.
// - Bit n of every enable and pending word belongs to interrupt n.
// - A pending, enabled interrupt that is not active is offered to the core by priority.
// - A disabled interrupt still goes pending but is never offered.
// - Writing ones to pending-set forces pending, even when disabled; reads show pending.
// - Setting pending on an already pending interrupt changes nothing.
// - Writing ones to pending-clear removes pending; reads show pending.
// - Pending-clear never touches the active state.
// - Each 8-bit priority field keeps value 0..3 in bits 7:6; lower wins.
// - Priority bits 5:0 read zero and ignore writes.
// - Priority words accept only full 32-bit writes.
// - Interrupt M lives in priority word M/4, byte lane M mod 4.
// - Pulse lines are sampled on rising pclk and a pulse latches pending.
// - Pending is set by high line while not active, rising edge, or software.
// - Handler entry clears pending and sets active.
// - Level return: line high makes pending again, else inactive.
// - Pulse during handler gives active and pending; pending after return.
// - Clearing pending of a level interrupt with line high changes nothing.
// - Pulse pending clear: pending becomes inactive, active-pending becomes active.
`timescale 1ns/10ps
`include "irq_ctrl_defines.vh"
module nested_interrupt_state_ctrl #(
  parameter NUM_IRQ = 32,
  parameter NUM_W = 5,
  parameter PRIO_W = 2
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NUM_IRQ-1:0] irq_lines,
  input wire isr_enter,
  input wire [NUM_W-1:0] isr_enter_num,
  input wire isr_return,
  input wire [NUM_W-1:0] isr_return_num,
  output wire take_req,
  output wire [NUM_W-1:0] take_num,
  output wire [PRIO_W-1:0] take_prio,
  output wire [NUM_IRQ-1:0] pending_state,
  output wire [NUM_IRQ-1:0] active_state
);

  reg [NUM_IRQ-1:0] enable_ff;
  reg [NUM_IRQ-1:0] pending_ff;
  reg [NUM_IRQ-1:0] active_ff;
  reg [NUM_IRQ-1:0] pulse_type_ff;
  reg [NUM_IRQ-1:0] line_prev_ff;
  reg [2*NUM_IRQ-1:0] prio_ff;
  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg take_req_ff;
  reg [NUM_W-1:0] take_num_ff;
  reg [PRIO_W-1:0] take_prio_ff;

  reg [NUM_IRQ-1:0] nxt_enable;
  reg [NUM_IRQ-1:0] nxt_pending;
  reg [NUM_IRQ-1:0] nxt_active;
  reg [NUM_IRQ-1:0] nxt_pulse_type;
  reg [2*NUM_IRQ-1:0] nxt_prio;
  reg [31:0] rd_word;
  reg addr_err;
  reg sel_en_set;
  reg sel_en_clr;
  reg sel_pend_set;
  reg sel_pend_clr;
  reg sel_prio;
  reg sel_type;
  reg best_valid;
  reg [NUM_W-1:0] best_num;
  reg [PRIO_W-1:0] best_prio;
  reg [NUM_IRQ-1:0] enter_vec;
  reg [NUM_IRQ-1:0] return_vec;
  reg [NUM_IRQ-1:0] hw_set;
  reg [NUM_IRQ-1:0] sw_set;
  reg [NUM_IRQ-1:0] pend_clr;
  reg [NUM_IRQ-1:0] candidates;
  reg [PRIO_W-1:0] prio_n;

  wire [NUM_IRQ-1:0] line_level;
  wire [NUM_IRQ-1:0] line_rise;
  wire access_phase;
  wire commit_write;
  wire [2:0] prio_word;
  integer i;
  integer j;
  integer k;

  irq_line_sync #(
    .WIDTH(NUM_IRQ)
  ) u_line_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(irq_lines),
    .level_out(line_level)
  );

  assign line_rise = line_level & ~line_prev_ff;
  assign access_phase = psel & penable;
  // Writes land on the same edge at which the master samples pready high.
  assign commit_write = access_phase & pready_ff & pwrite & ~pslverr_ff;
  assign prio_word = paddr[4:2];

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign take_req = take_req_ff;
  assign take_num = take_num_ff;
  assign take_prio = take_prio_ff;
  assign pending_state = pending_ff;
  assign active_state = active_ff;

  // Address decode and read data.
  always @* begin
    sel_en_set = 1'b0;
    sel_en_clr = 1'b0;
    sel_pend_set = 1'b0;
    sel_pend_clr = 1'b0;
    sel_prio = 1'b0;
    sel_type = 1'b0;
    addr_err = 1'b0;
    rd_word = `READ_ZERO;
    if (paddr[1:0] != 2'h0) begin
      addr_err = 1'b1;
    end else if (paddr == `ENABLE_SET_OFS) begin
      sel_en_set = 1'b1;
      rd_word = enable_ff;
    end else if (paddr == `ENABLE_CLEAR_OFS) begin
      sel_en_clr = 1'b1;
      rd_word = enable_ff;
    end else if (paddr == `PENDING_SET_OFS) begin
      sel_pend_set = 1'b1;
      rd_word = pending_ff;
    end else if (paddr == `PENDING_CLEAR_OFS) begin
      sel_pend_clr = 1'b1;
      rd_word = pending_ff;
    end else if (paddr >= `PRIORITY_BASE_OFS && paddr <= `PRIORITY_LAST_OFS) begin
      sel_prio = 1'b1;
      addr_err = (pwrite && pstrb != `FULL_WORD_STROBE);
      for (j = 0; j < `PRIO_LANES; j = j + 1) begin
        // Lane j of word k is interrupt 4k+j; the low six bits stay zero.
        rd_word[8*j+`PRIO_FIELD_LSB +: PRIO_W] =
          prio_ff[2*(`PRIO_LANES*prio_word+j) +: PRIO_W];
      end
    end else if (paddr == `ACTIVE_STATUS_OFS) begin
      rd_word = active_ff;
      addr_err = pwrite;
    end else if (paddr == `TRIGGER_TYPE_OFS) begin
      sel_type = 1'b1;
      rd_word = pulse_type_ff;
    end else if (paddr == `LINE_LEVEL_OFS) begin
      rd_word = line_level;
      addr_err = pwrite;
    end else begin
      addr_err = 1'b1;
    end
  end

  // Enable, priority and trigger type updates from software.
  always @* begin
    nxt_enable = enable_ff;
    nxt_prio = prio_ff;
    nxt_pulse_type = pulse_type_ff;
    if (commit_write && sel_en_set) begin
      nxt_enable = enable_ff | pwdata;
    end
    if (commit_write && sel_en_clr) begin
      nxt_enable = enable_ff & ~pwdata;
    end
    if (commit_write && sel_prio) begin
      for (k = 0; k < `PRIO_LANES; k = k + 1) begin
        nxt_prio[2*(`PRIO_LANES*prio_word+k) +: PRIO_W] =
          pwdata[8*k+`PRIO_FIELD_LSB +: PRIO_W];
      end
    end
    if (commit_write && sel_type) begin
      nxt_pulse_type = pwdata;
    end
  end

  // Pending and active state of every interrupt.
  always @* begin
    enter_vec = {NUM_IRQ{1'b0}};
    return_vec = {NUM_IRQ{1'b0}};
    if (isr_enter) begin
      enter_vec[isr_enter_num] = 1'b1;
    end
    if (isr_return) begin
      return_vec[isr_return_num] = 1'b1;
    end
    nxt_active = (active_ff & ~return_vec) | enter_vec;
    // Pending-clear only ever affects the pending bit.
    pend_clr = enter_vec;
    if (commit_write && sel_pend_clr) begin
      pend_clr = pend_clr | pwdata;
    end
    sw_set = {NUM_IRQ{1'b0}};
    if (commit_write && sel_pend_set) begin
      sw_set = pwdata;
    end
    // A level line asks again as long as the interrupt is not active, which re-arms
    // it on return and keeps it pending across a software clear.
    hw_set = (~pulse_type_ff & line_level & ~nxt_active)
           | (pulse_type_ff & line_rise);
    // Setting wins over clearing in the same cycle, so no event is lost.
    nxt_pending = (pending_ff & ~pend_clr) | hw_set | sw_set;
  end

  // Highest priority candidate; scanning downward lets ties go to the lowest number.
  always @* begin
    candidates = pending_ff & enable_ff & ~active_ff;
    best_valid = 1'b0;
    best_num = {NUM_W{1'b0}};
    best_prio = `PRIO_LOWEST;
    prio_n = `PRIO_LOWEST;
    for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
      prio_n = prio_ff[2*i +: PRIO_W];
      if (candidates[i] && prio_n <= best_prio) begin
        best_valid = 1'b1;
        best_num = i[NUM_W-1:0];
        best_prio = prio_n;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= `ENABLE_RESET;
      pending_ff <= `PENDING_RESET;
      active_ff <= `ACTIVE_RESET;
      pulse_type_ff <= `TRIGGER_TYPE_RESET;
      prio_ff <= `PRIORITY_RESET;
      line_prev_ff <= {NUM_IRQ{1'b0}};
    end else begin
      enable_ff <= nxt_enable;
      pending_ff <= nxt_pending;
      active_ff <= nxt_active;
      pulse_type_ff <= nxt_pulse_type;
      prio_ff <= nxt_prio;
      line_prev_ff <= line_level;
    end
  end

  // APB answer: one wait state, so every bus output comes from a flip-flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `READ_ZERO;
    end else if (access_phase && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= addr_err;
      prdata_ff <= (pwrite || addr_err) ? `READ_ZERO : rd_word;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `READ_ZERO;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      take_req_ff <= 1'b0;
      take_num_ff <= {NUM_W{1'b0}};
      take_prio_ff <= `PRIO_LOWEST;
    end else begin
      take_req_ff <= best_valid;
      take_num_ff <= best_num;
      take_prio_ff <= best_prio;
    end
  end

endmodule

/* bench/irq_ctrl_asserts.sv */
/*
  Concurrent checks on the ports of the interrupt controller.
  Assumes one pclk domain and the one-wait-state APB answer of the design.
*/
`timescale 1ns/10ps
module irq_ctrl_asserts #(
  parameter NUM_IRQ = 32,
  parameter NUM_W = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire isr_enter,
  input wire [NUM_W-1:0] isr_enter_num,
  input wire isr_return,
  input wire [NUM_W-1:0] isr_return_num,
  input wire take_req,
  input wire [NUM_W-1:0] take_num,
  input wire [NUM_IRQ-1:0] pending_state,
  input wire [NUM_IRQ-1:0] active_state
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_WAIT: assert property (
    psel && penable && !pready |=> pready) else $error("no answer after one wait");
  AST_READY_CAUSE: assert property (
    pready |-> $past(psel && penable && !pready)) else $error("answer without access");
  AST_READY_PULSE: assert property (
    pready |=> !pready) else $error("answer longer than one cycle");
  AST_ERR_WITH_READY: assert property (
    pslverr |-> pready) else $error("error outside answer");
  AST_RDATA_IDLE: assert property (
    !pready |-> prdata == 32'h00000000) else $error("read data outside answer");
  AST_ENTER_ACTIVE: assert property (
    isr_enter |=> active_state[$past(isr_enter_num)]) else $error("entry not active");
  AST_RETURN_CLEAR: assert property (
    isr_return |=> !active_state[$past(isr_return_num)]) else $error("still active");
  AST_ACTIVE_CAUSE: assert property (
    $changed(active_state) |-> $past(isr_enter || isr_return)) else $error("active moved");
  AST_TAKE_PENDING: assert property (
    take_req |-> (($past(pending_state) & ~$past(active_state)) >> take_num) & 1)
    else $error("offered interrupt not pending");
  cover property (pready && pslverr);
  cover property (take_req);
  cover property (isr_return);
endmodule
bind nested_interrupt_state_ctrl irq_ctrl_asserts #(.NUM_IRQ(NUM_IRQ), .NUM_W(NUM_W)) sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .isr_enter(isr_enter),
  .isr_enter_num(isr_enter_num), .isr_return(isr_return), .isr_return_num(isr_return_num),
  .take_req(take_req), .take_num(take_num), .pending_state(pending_state),
  .active_state(active_state));

/* bench/core_model.sv */
/*
  Processor core model: takes the offered interrupt while go is high, stays in the
  handler for HOLD cycles, then returns. Numbers are scrambled outside strobes.
*/
`timescale 1ns/10ps
module core_model #(
  parameter HOLD = 30
) (
  input wire pclk,
  input wire go,
  input wire take_req,
  input wire [4:0] take_num,
  output logic isr_enter,
  output logic [4:0] isr_enter_num,
  output logic isr_return,
  output logic [4:0] isr_return_num
);
  logic [4:0] num;
  initial begin
    isr_enter = 1'b0;
    isr_return = 1'b0;
    isr_enter_num = 5'h00;
    isr_return_num = 5'h00;
    forever begin
      @(posedge pclk);
      if (go && take_req === 1'b1) begin
        num = take_num;
        isr_enter <= 1'b1;
        isr_enter_num <= num;
        @(posedge pclk);
        isr_enter <= 1'b0;
        isr_enter_num <= ~num;
        repeat (HOLD) @(posedge pclk);
        isr_return <= 1'b1;
        isr_return_num <= num;
        @(posedge pclk);
        isr_return <= 1'b0;
        isr_return_num <= ~num;
        @(posedge pclk);
      end
    end
  end
endmodule

/* bench/nested_interrupt_state_ctrl_bench.sv */
/*
  Self-checking bench of the interrupt controller with the core model.
  Assumes APB answers after one wait state and a line takes under eight cycles to latch.
*/
`timescale 1ns/10ps
module nested_interrupt_state_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, go, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, irq, rdat, en, r, c;
  logic [3:0] pstrb;
  logic [1:0] pr [32];
  int miscompares, samples_checked, b;
  wire [31:0] prdata, pend, act;
  wire pready, pslverr, take_req, ie, ir;
  wire [4:0] take_num, ien, irn;
  wire [1:0] take_prio;
  nested_interrupt_state_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_lines(irq),
    .isr_enter(ie), .isr_enter_num(ien), .isr_return(ir), .isr_return_num(irn),
    .take_req(take_req), .take_num(take_num), .take_prio(take_prio),
    .pending_state(pend), .active_state(act));
  core_model core (.pclk(pclk), .go(go), .take_req(take_req), .take_num(take_num),
    .isr_enter(ie), .isr_enter_num(ien), .isr_return(ir), .isr_return_num(irn));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // One idle cycle follows each transfer so no strobe is driven twice in a time step.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %0t no bus answer", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while ((sel ? ir : ie) !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    if ((sel ? ir : ie) !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %0t no handler strobe", $time);
    end
    go <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic pulse(input int k);
    irq[k] <= 1'b1;
    @(posedge pclk);
    irq[k] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  // Lowest priority value wins; a tie keeps the lower number.
  function automatic int pick(input logic [31:0] m);
    int w;
    w = -1;
    for (int i = 0; i < 32; i++) if (m[i] && (w < 0 || pr[i] < pr[w])) w = i;
    return w;
  endfunction
  task automatic complete_run;
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    complete_run;
  end
  initial begin
    {presetn, psel, penable, pwrite, go} = 5'h00;
    {paddr, pwdata, pstrb, irq} = 80'h0;
    void'($urandom(32'h24d7d413));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 12'h100, 32'h0, 4'hF);
    chk(rdat, 32'h0);
    en = 32'h0;
    repeat (4) begin
      r = $urandom;
      c = $urandom;
      xfer(1'b1, 12'h100, r, 4'hF);
      xfer(1'b1, 12'h180, c, 4'hF);
      en = (en | r) & ~c;
      xfer(1'b0, 12'h100, 32'h0, 4'hF);
      chk(rdat, en);
      xfer(1'b0, 12'h180, 32'h0, 4'hF);
      chk(rdat, en);
      for (int k = 0; k < 8; k++) begin
        c = $urandom;
        xfer(1'b1, 12'h400 + 12'(4 * k), c, 4'hF);
        for (int j = 0; j < 4; j++) pr[4 * k + j] = c[8 * j + 6 +: 2];
        xfer(1'b0, 12'h400 + 12'(4 * k), 32'h0, 4'hF);
        chk(rdat, c & 32'hC0C0C0C0);
      end
      xfer(1'b1, 12'h280, 32'hFFFFFFFF, 4'hF);
      r = $urandom;
      xfer(1'b1, 12'h200, r, 4'hF);
      xfer(1'b1, 12'h200, r, 4'hF);
      xfer(1'b0, 12'h200, 32'h0, 4'hF);
      chk(rdat, r);
      repeat (3) @(posedge pclk);
      b = pick(r & en);
      chk(take_req, b >= 0);
      if (b >= 0) chk({take_num, take_prio}, {b[4:0], pr[b]});
      c = $urandom;
      xfer(1'b1, 12'h280, c, 4'hF);
      xfer(1'b0, 12'h280, 32'h0, 4'hF);
      chk(rdat, r & ~c);
    end
    xfer(1'b1, 12'h41C, 32'h0, 4'h3);
    chk(rerr, 1'b1);
    xfer(1'b0, 12'h41C, 32'h0, 4'hF);
    chk(rdat, {pr[31], 6'h00, pr[30], 6'h00, pr[29], 6'h00, pr[28], 6'h00});
    xfer(1'b0, 12'h010, 32'h0, 4'hF);
    chk({rerr, rdat}, 33'h100000000);
    xfer(1'b1, 12'h180, 32'hFFFFFFFF, 4'hF);
    xfer(1'b1, 12'h280, 32'hFFFFFFFF, 4'hF);
    xfer(1'b1, 12'h100, 32'h00000200, 4'hF);
    irq[9] <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(pend[9], 1'b1);
    xfer(1'b0, 12'h308, 32'h0, 4'hF);
    chk(rdat, 32'h00000200);
    xfer(1'b1, 12'h280, 32'h00000200, 4'hF);
    chk(pend[9], 1'b1);
    go <= 1'b1;
    wait_for(0);
    chk({act[9], pend[9]}, 2'b10);
    xfer(1'b0, 12'h300, 32'h0, 4'hF);
    chk(rdat, 32'h00000200);
    xfer(1'b1, 12'h300, 32'h0, 4'hF);
    chk({rerr, act[9]}, 2'b11);
    wait_for(1);
    chk({act[9], pend[9]}, 2'b01);
    irq[9] <= 1'b0;
    go <= 1'b1;
    wait_for(0);
    wait_for(1);
    chk({act[9], pend[9]}, 2'b00);
    xfer(1'b1, 12'h304, 32'h00001000, 4'hF);
    xfer(1'b0, 12'h304, 32'h0, 4'hF);
    chk(rdat, 32'h00001000);
    xfer(1'b1, 12'h100, 32'h00001000, 4'hF);
    pulse(12);
    chk(pend[12], 1'b1);
    xfer(1'b1, 12'h280, 32'h00001000, 4'hF);
    chk(pend[12], 1'b0);
    pulse(12);
    go <= 1'b1;
    wait_for(0);
    pulse(12);
    chk({act[12], pend[12]}, 2'b11);
    xfer(1'b1, 12'h280, 32'h00001000, 4'hF);
    chk({act[12], pend[12]}, 2'b10);
    wait_for(1);
    chk({act[12], pend[12]}, 2'b00);
    complete_run;
  end
endmodule
